/* hdl/sbt_tap.sv */
// Overview of operation
// R1: sample tms/tdi on rise, tdo on fall
// R2: tms and tdi read high when open
// R3: shift in at msb, out at lsb
// R4: tdo driven only while shifting
// R5: five tms-high rises reset the controller
// R6: power-up reset floats tdo without tck
// R7: one data register selected by instruction
// R8: three-bit instruction register shifted in shift-ir
// R9: idcode loaded at power-up and reset
// R10: capture-ir loads 01 into low bits
// R11: single-bit bypass, cleared under bypass
// R12: boundary register captures ring, shifts in dr
// R13: idcode captures hardwired 32-bit code
// R14: idcode shifts identification register
// R15: instruction takes effect at update-ir only
// R16: all-zero code acts as sample, outputs float
// R17: scans never drive memory or preload buffers
// R18: sample-z shifts boundary, outputs float
// R19: sample captures pins at capture-dr
// R20: controller avoids the three reserved codes
// R21: test clock no faster than 20 mhz
// R22: standard sixteen-state controller driven by tms
// R23: bypass is all ones, reserved select bypass
`timescale 1ns/10ps
`default_nettype none
module sbt_tap #(
  parameter int          BSR_W   = sbt_pkg::BSR_W_DEF,
  parameter logic [31:0] ID_CODE = sbt_pkg::ID_CODE_DEF
) (
  // system clock and reset
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  // test port pins
  input  wire logic             tck_in,
  input  wire logic             tms_in,
  input  wire logic             tdi_in,
  output logic                  tdo_out,
  output logic                  tdo_oe_n_out,
  // i/o ring to observe
  input  wire logic [BSR_W-1:0] ring_in,
  // memory output float request
  output logic                  mem_hiz_out,
  // captured snapshot stream
  output logic                  snap_valid_out,
  output logic [BSR_W+2:0]      snap_data_out,
  input  wire logic             snap_ready_in,
  output logic                  snap_drop_out
);
  logic [2:0]             tck_s;
  logic [1:0]             tms_s;
  logic [1:0]             tdi_s;
  logic [BSR_W-1:0]       ring_s1;
  logic [BSR_W-1:0]       ring_s2;
  logic                   tck_rise;
  logic                   tck_fall;
  sbt_pkg::sbt_state_t    state;
  sbt_pkg::sbt_state_t    next_state;
  logic [2:0]             tms_run;
  logic [2:0]             ir_shift;
  logic [2:0]             ir;
  logic                   bypass;
  logic [31:0]            idreg;
  logic [BSR_W-1:0]       bsr;
  logic                   shift_out;
  logic                   fifo_ready;
  logic                   fifo_valid;
  logic [BSR_W+2:0]       fifo_data;
  sbt_pkg::sbt_snap_t     snap;

  // decode of the active instruction to the selected data register
  function automatic logic sel_bsr(input logic [2:0] ins);
    sel_bsr = ins == sbt_pkg::INS_EXTEST || ins == sbt_pkg::INS_SAMPLE ||
              ins == sbt_pkg::INS_SAMPLEZ;
  endfunction

  // pins come from the test clock domain; tms and tdi pull-ups are pad cells, so those reset to high, tck to low
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tck_s <= 3'h0;
      tms_s <= 2'h3; // R2
      tdi_s <= 2'h3; // R2
    end else begin
      tck_s <= {tck_s[1:0], tck_in};
      tms_s <= {tms_s[0], tms_in};
      tdi_s <= {tdi_s[0], tdi_in};
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ring_s1 <= '0;
      ring_s2 <= '0;
    end else begin
      ring_s1 <= ring_in;
      ring_s2 <= ring_s1;
    end
  end

  assign tck_rise = tck_s[1] && !tck_s[2]; // R1
  assign tck_fall = !tck_s[1] && tck_s[2]; // R1

  always_comb begin
    next_state = state;
    unique case (state) // R22
      sbt_pkg::ST_RESET:    next_state = tms_s[1] ? sbt_pkg::ST_RESET : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_IDLE:     next_state = tms_s[1] ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_DR:   next_state = tms_s[1] ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
      sbt_pkg::ST_CAP_DR:   next_state = tms_s[1] ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_SHIFT_DR: next_state = tms_s[1] ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_EXIT1_DR: next_state = tms_s[1] ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PAUSE_DR;
      sbt_pkg::ST_PAUSE_DR: next_state = tms_s[1] ? sbt_pkg::ST_EXIT2_DR : sbt_pkg::ST_PAUSE_DR;
      sbt_pkg::ST_EXIT2_DR: next_state = tms_s[1] ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_UPD_DR:   next_state = tms_s[1] ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_IR:   next_state = tms_s[1] ? sbt_pkg::ST_RESET : sbt_pkg::ST_CAP_IR;
      sbt_pkg::ST_CAP_IR:   next_state = tms_s[1] ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_SHIFT_IR: next_state = tms_s[1] ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_EXIT1_IR: next_state = tms_s[1] ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PAUSE_IR;
      sbt_pkg::ST_PAUSE_IR: next_state = tms_s[1] ? sbt_pkg::ST_EXIT2_IR : sbt_pkg::ST_PAUSE_IR;
      sbt_pkg::ST_EXIT2_IR: next_state = tms_s[1] ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_UPD_IR:   next_state = tms_s[1] ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
    endcase
  end

  // the counter forces reset even if a walk through the diagram would take longer
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state   <= sbt_pkg::ST_RESET; // R6
      tms_run <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s[1]) begin
        tms_run <= 3'h0;
        state   <= next_state;
      end else if (tms_run == 3'h4) begin
        tms_run <= 3'h4;
        state   <= sbt_pkg::ST_RESET; // R5
      end else begin
        tms_run <= tms_run + 3'h1;
        state   <= next_state;
      end
    end
  end

  // instruction shift and update
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ir_shift <= sbt_pkg::INS_IDCODE;
      ir       <= sbt_pkg::INS_IDCODE; // R9
    end else if (state == sbt_pkg::ST_RESET) begin
      // load at once on entry, so the float request clears without another tck
      ir <= sbt_pkg::INS_IDCODE; // R9
    end else if (tck_rise) begin
      unique case (state)
        sbt_pkg::ST_CAP_IR:   ir_shift <= {1'b0, sbt_pkg::IR_CAPTURE}; // R10
        sbt_pkg::ST_SHIFT_IR: ir_shift <= {tdi_s[1], ir_shift[2:1]}; // R3 R8
        sbt_pkg::ST_UPD_IR:   ir <= ir_shift; // R15
        default: ;
      endcase
    end
  end

  // data registers; captures only, nothing is ever driven into the memory
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bypass <= 1'b0;
      idreg  <= '0;
      bsr    <= '0;
    end else if (tck_rise) begin
      if (state == sbt_pkg::ST_CAP_DR) begin
        bypass <= 1'b0; // R11
        if (ir == sbt_pkg::INS_IDCODE) begin
          idreg <= ID_CODE; // R13
        end
        if (sel_bsr(ir)) begin
          bsr <= ring_s2; // R12 R19 R17
        end
      end else if (state == sbt_pkg::ST_SHIFT_DR) begin
        if (ir == sbt_pkg::INS_IDCODE) begin
          idreg <= {tdi_s[1], idreg[31:1]}; // R3 R14
        end else if (sel_bsr(ir)) begin
          bsr <= {tdi_s[1], bsr[BSR_W-1:1]}; // R3 R12 R18
        end else begin
          bypass <= tdi_s[1]; // R11 R23
        end
      end
    end
  end

  always_comb begin
    if (state == sbt_pkg::ST_SHIFT_IR) begin
      shift_out = ir_shift[0];
    end else if (ir == sbt_pkg::INS_IDCODE) begin
      shift_out = idreg[0]; // R7
    end else if (sel_bsr(ir)) begin
      shift_out = bsr[0]; // R7
    end else begin
      shift_out = bypass; // R7 R23
    end
  end

  // tdo changes only on the falling test clock edge
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tdo_out      <= 1'b0;
      tdo_oe_n_out <= 1'b1; // R6
    end else if (tck_fall) begin // R1
      tdo_out      <= shift_out;
      tdo_oe_n_out <= !(state == sbt_pkg::ST_SHIFT_DR || state == sbt_pkg::ST_SHIFT_IR); // R4
    end
  end

  // float request follows the active instruction, updated on the system clock
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_hiz_out <= 1'b0;
    end else begin
      mem_hiz_out <= ir == sbt_pkg::INS_EXTEST || ir == sbt_pkg::INS_SAMPLEZ; // R16 R18
    end
  end

  // each boundary capture is queued for the observer; a full queue drops and flags
  assign snap.ins  = ir;
  assign snap.ring = ring_s2[7:0];

  sbt_fifo #(
    .W (BSR_W + 3),
    .D (sbt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (tck_rise && state == sbt_pkg::ST_CAP_DR && sel_bsr(ir)),
    .in_data_in    (snap),
    .in_ready_out  (fifo_ready),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (snap_ready_in && !snap_valid_out)
  );

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      snap_valid_out <= 1'b0;
      snap_data_out  <= '0;
    end else if (snap_valid_out) begin
      snap_valid_out <= !snap_ready_in;
    end else if (fifo_valid && snap_ready_in) begin
      snap_valid_out <= 1'b1;
      snap_data_out  <= fifo_data;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      snap_drop_out <= 1'b0;
    end else begin
      snap_drop_out <= tck_rise && state == sbt_pkg::ST_CAP_DR && sel_bsr(ir) && !fifo_ready;
    end
  end
endmodule
`default_nettype wire

/* shared/sbt_pkg.sv */
package sbt_pkg;

  // tap controller states, gray coded along the usual walk
  typedef enum logic [3:0] {
    ST_RESET     = 4'h0,
    ST_IDLE      = 4'h1,
    ST_SEL_DR    = 4'h3,
    ST_CAP_DR    = 4'h2,
    ST_SHIFT_DR  = 4'h6,
    ST_EXIT1_DR  = 4'h7,
    ST_PAUSE_DR  = 4'h5,
    ST_EXIT2_DR  = 4'h4,
    ST_UPD_DR    = 4'hC,
    ST_SEL_IR    = 4'hD,
    ST_CAP_IR    = 4'hF,
    ST_SHIFT_IR  = 4'hE,
    ST_EXIT1_IR  = 4'hA,
    ST_PAUSE_IR  = 4'hB,
    ST_EXIT2_IR  = 4'h9,
    ST_UPD_IR    = 4'h8
  } sbt_state_t;

  localparam int          IR_W        = 3;
  localparam int          ID_W        = 32;
  localparam int          BSR_W_DEF   = 8;
  localparam logic [2:0]  INS_EXTEST  = 3'h0;
  localparam logic [2:0]  INS_IDCODE  = 3'h1;
  localparam logic [2:0]  INS_SAMPLEZ = 3'h2;
  localparam logic [2:0]  INS_SAMPLE  = 3'h4;
  localparam logic [2:0]  INS_BYPASS  = 3'h7;
  localparam logic [1:0]  IR_CAPTURE  = 2'h1;
  // arbitrary neutral identification value, bit 0 set as presence marker
  localparam logic [31:0] ID_CODE_DEF = 32'h0000_0001;
  localparam int          FIFO_DEPTH  = 16;

  // one captured snapshot of the i/o ring plus its instruction
  typedef struct packed {
    logic [2:0]  ins;
    logic [7:0]  ring;
  } sbt_snap_t;

endpackage

/* hdl/sbt_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module sbt_fifo #(
  parameter int W = 11,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         mclk_in,
  input  wire logic         resetn_in,
  // fill side
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  // drain side
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         push;
  logic         pop;

  assign in_ready_out  = (wr_ptr - rd_ptr) != (AW+1)'(D);
  assign out_valid_out = wr_ptr != rd_ptr;
  assign out_data_out  = mem[rd_ptr[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* test/sbt_tap_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module sbt_tap_checker #(
  parameter int BSR_W = 8
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  // test port
  input  wire logic             tck_in,
  input  wire logic             tms_in,
  input  wire logic             tdo_out,
  input  wire logic             tdo_oe_n_out,
  // memory and snapshots
  input  wire logic             mem_hiz_out,
  input  wire logic             snap_valid_out,
  input  wire logic [BSR_W+2:0] snap_data_out,
  input  wire logic             snap_ready_in,
  input  wire logic             snap_drop_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  logic [2:0] tck_s;
  logic [1:0] tms_s;
  logic [3:0] ones;
  // same sync depth as the port, so rises line up with its own
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tck_s <= 3'h0;
      tms_s <= 2'h3;
      ones  <= 4'h0;
    end else begin
      tck_s <= {tck_s[1:0], tck_in};
      tms_s <= {tms_s[0], tms_in};
      if (tck_s[2:1] == 2'b01)
        ones <= !tms_s[1] ? 4'h0 : (ones == 4'h8 ? ones : ones + 4'h1);
    end
  end
  tdo_fall_a: assert property ($changed(tdo_out) |-> !tck_in)
    else $error("tdo moved while tck high");
  oe_fall_a: assert property ($changed(tdo_oe_n_out) |-> !tck_in)
    else $error("tdo enable moved while tck high");
  oe_idle_a: assert property (ones >= 4'h2 |-> tdo_oe_n_out)
    else $error("tdo driven outside shift");
  hiz_update_a: assert property ($changed(mem_hiz_out) |-> tck_in)
    else $error("float request moved off update");
  tms_reset_a: assert property (ones == 4'h5 |-> ##[0:8] !mem_hiz_out)
    else $error("five tms rises did not restore idcode");
  reset_float_a: assert property ($rose(resetn_in) |-> tdo_oe_n_out && !mem_hiz_out)
    else $error("port not idle after reset");
  snap_hold_a: assert property (snap_valid_out && !snap_ready_in
    |=> snap_valid_out && $stable(snap_data_out))
    else $error("snapshot changed before taken");
  drop_pulse_a: assert property (snap_drop_out |=> !snap_drop_out)
    else $error("drop flag longer than one cycle");
  snap_code_a: assert property (snap_valid_out
    |-> snap_data_out[BSR_W+2:BSR_W] inside {3'h0, 3'h2, 3'h4})
    else $error("snapshot under a non-scan instruction");
  cover property (snap_drop_out);
  cover property (ones == 4'h5);
  cover property (!tdo_oe_n_out && mem_hiz_out);
endmodule
bind sbt_tap sbt_tap_checker #(.BSR_W(BSR_W)) u_sbt_tap_checker (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .tck_in(tck_in), .tms_in(tms_in),
  .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out), .mem_hiz_out(mem_hiz_out),
  .snap_valid_out(snap_valid_out), .snap_data_out(snap_data_out),
  .snap_ready_in(snap_ready_in), .snap_drop_out(snap_drop_out));
`default_nettype wire

/* test/sbt_jtag_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sbt_jtag_model (
  // phase reference only
  input  wire logic mclk_in,
  // test port pins
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in,
  input  wire logic tdo_oe_n_in
);
  logic tdo_wire;
  // a floating pin shows the inverse, so a stale bit never passes
  assign tdo_wire = tdo_oe_n_in ? ~tdo_in : tdo_in;
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // 125 ns period, tck stands low between calls
  task automatic clk_bit(input logic ms, input logic di, output logic dout);
    tms_out = ms;
    tdi_out = di;
    #62.5;
    dout = tdo_wire;
    tck_out = 1'b1;
    #62.5;
    tck_out = 1'b0;
  endtask
  task automatic go_reset();
    logic d;
    @(negedge mclk_in);
    #2;
    repeat (5) clk_bit(1'b1, 1'b1, d);
    clk_bit(1'b0, 1'b1, d);
  endtask
  // from idle; tck edges kept off mclk edges so sampling is deterministic
  task automatic scan(input logic ir, input int n, input logic [32:0] din,
                      output logic [32:0] dout);
    logic d;
    dout = '0;
    @(negedge mclk_in);
    #2;
    clk_bit(1'b1, 1'b1, d);
    if (ir)
      clk_bit(1'b1, 1'b1, d);
    clk_bit(1'b0, 1'b1, d);
    clk_bit(1'b0, 1'b1, d);
    for (int i = 0; i < n; i++) begin
      clk_bit(i == n - 1, din[i], d);
      dout[i] = d;
    end
    clk_bit(1'b1, 1'b1, d);
    clk_bit(1'b0, 1'b1, d);
  endtask
endmodule
`default_nettype wire

/* test/sbt_tap_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
    end \
  end
module sbt_tap_tb;
  localparam int BW = sbt_pkg::BSR_W_DEF;
  logic          mclk, resetn, tck, tms, tdi, tdo, tdo_oe_n, mem_hiz;
  logic          snap_valid, snap_ready, snap_drop;
  logic [BW-1:0] ring;
  logic [BW+2:0] snap_data, exp_snap;
  logic [BW+2:0] exp_q[$];
  logic [31:0]   seed = 32'hCB8C928A;
  logic [32:0]   dout;
  logic [2:0]    codes [7] = '{3'h7, 3'h2, 3'h4, 3'h0, 3'h7, 3'h4, 3'h2};
  int            num_errors = 0, tests_run = 0, drops = 0;
  sbt_tap u_sbt_tap (.mclk_in(mclk), .resetn_in(resetn), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .ring_in(ring),
    .mem_hiz_out(mem_hiz), .snap_valid_out(snap_valid), .snap_data_out(snap_data),
    .snap_ready_in(snap_ready), .snap_drop_out(snap_drop));
  sbt_jtag_model u_sbt_jtag_model (.mclk_in(mclk), .tck_out(tck), .tms_out(tms),
    .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n));
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (snap_drop === 1'b1)
      drops++;
    if (snap_valid === 1'b1 && snap_ready === 1'b1) begin
      exp_snap = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
      `CHECK("snapshot", exp_snap, snap_data)
    end
  end
  task automatic id_test();
    u_sbt_jtag_model.scan(1'b0, 32, 33'h0, dout);
    `CHECK("idcode", sbt_pkg::ID_CODE_DEF, dout[31:0])
  endtask
  task automatic run_ins(input logic [2:0] ins);
    logic [32:0] din;
    logic [31:0] t;
    logic        bsr, hiz;
    hiz = ins == sbt_pkg::INS_EXTEST || ins == sbt_pkg::INS_SAMPLEZ;
    bsr = hiz || ins == sbt_pkg::INS_SAMPLE;
    u_sbt_jtag_model.scan(1'b1, 3, {30'h0, ins}, dout);
    `CHECK("ir_capture", sbt_pkg::IR_CAPTURE, dout[1:0])
    `CHECK("mem_hiz", hiz, mem_hiz)
    t = next_rand();
    din = {next_rand(), 1'b0};
    @(negedge mclk);
    ring = t[BW-1:0];
    // with ready low the queue length equals the fifo fill
    if (bsr && exp_q.size() < sbt_pkg::FIFO_DEPTH)
      exp_q.push_back({ins, t[BW-1:0]});
    u_sbt_jtag_model.scan(1'b0, bsr ? BW : 33, din, dout);
    if (bsr)
      `CHECK("boundary", t[BW-1:0], dout[BW-1:0])
    else
      `CHECK("bypass", {din[31:0], 1'b0}, dout)
  endtask
  task automatic tally_and_finish();
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    ring = '0;
    snap_ready = 1'b1;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    `CHECK("oe_after_reset", 1'b1, tdo_oe_n)
    u_sbt_jtag_model.go_reset();
    id_test();
    $display("test idcode done");
    foreach (codes[i])
      run_ins(codes[i]);
    $display("test instructions done");
    u_sbt_jtag_model.go_reset();
    id_test();
    $display("test tms reset done");
    @(negedge mclk);
    snap_ready = 1'b0;
    repeat (17) run_ins(sbt_pkg::INS_SAMPLE);
    `CHECK("drops", 1, drops)
    @(negedge mclk);
    snap_ready = 1'b1;
    for (int k = 0; k < 200 && exp_q.size() > 0; k++)
      @(posedge mclk);
    `CHECK("drained", 0, exp_q.size())
    $display("test fifo done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
